// ==== core/ifp_bank.sv ====
`default_nettype none
`include "ifp_consts.svh"

module ifp_bank #(
    parameter int SRC_COUNT = 32
) (
    input  wire logic                  core_clk,     // System clock
    input  wire logic                  reset_n,      // Async reset, low
    input  wire ifp_pkg::ifp_bus_s     busReq,       // Register bus request
    output logic [31:0]                rdData,       // Read data, next cycle
    input  wire logic [SRC_COUNT-1:0]  sourceEvent,  // Peripheral request pulses
    output ifp_pkg::ifp_request_s      coreReq,      // Request to the core
    output logic                       irq           // Event interrupt, level
);
    import ifp_pkg::*;

    localparam int PRIO_REGS = SRC_COUNT / 4;

    logic [SRC_COUNT-1:0]  flags;
    logic [SRC_COUNT-1:0]  enables;
    ifp_level_t            prio [SRC_COUNT];
    ifp_sub_t              sub  [SRC_COUNT];
    logic                  multiVector;
    ifp_level_t            latestLevel;
    logic [4:0]            latestVector;
    logic [`IFP_EV_COUNT-1:0] irqStatus;
    logic [`IFP_EV_COUNT-1:0] irqMask;

    ifp_request_s          next_coreReq;
    logic [31:0]           next_rdData;
    logic [`IFP_EV_COUNT-1:0] events;
    logic                  newPresent;

    // Word index of a priority register, or -1 when outside the range
    function automatic int ifp_prio_index(input logic [7:0] addr);
        int idx;
        idx = -1;
        if (addr >= `IFP_OFF_PRIO_FIRST && addr <= `IFP_OFF_PRIO_LAST
            && addr[1:0] == 2'h0) begin
            idx = int'(addr - `IFP_OFF_PRIO_FIRST) / 4;
        end
        if (idx >= PRIO_REGS) begin
            idx = -1;
        end
        return idx;
    endfunction : ifp_prio_index

    function automatic logic ifp_hit(input ifp_bus_s req,
                                     input logic [7:0] off);
        return req.wrEn && req.addr == off;
    endfunction : ifp_hit

    // Flag register: software writes, hardware sets
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            flags <= SRC_COUNT'(`IFP_RST_WORD);
        end else begin
            if (ifp_hit(busReq, `IFP_OFF_FLAG)) begin
                flags <= busReq.wrData[SRC_COUNT-1:0] | sourceEvent;
            end else begin
                flags <= flags | sourceEvent;
            end
        end
    end

    // Enable register
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            enables <= SRC_COUNT'(`IFP_RST_WORD);
        end else if (ifp_hit(busReq, `IFP_OFF_ENABLE)) begin
            enables <= busReq.wrData[SRC_COUNT-1:0];
        end
    end

    // Priority and subpriority fields, four sources to a word
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int s = 0; s < SRC_COUNT; s++) begin
                prio[s] <= `IFP_RST_PRI;
                sub[s]  <= `IFP_RST_SUB;
            end
        end else if (busReq.wrEn && ifp_prio_index(busReq.addr) >= 0) begin
            for (int k = 0; k < 4; k++) begin
                // Bits above each priority field are simply not stored
                prio[ifp_prio_index(busReq.addr) * 4 + k] <=
                    busReq.wrData[k*`IFP_SLOT_STRIDE+`IFP_PRI_LSB +: 3];
                sub[ifp_prio_index(busReq.addr) * 4 + k] <=
                    busReq.wrData[k*`IFP_SLOT_STRIDE+`IFP_SUB_LSB +: 2];
            end
        end
    end

    // Vector mode select
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            multiVector <= 1'b0;
        end else if (ifp_hit(busReq, `IFP_OFF_CONTROL)) begin
            multiVector <= busReq.wrData[`IFP_CTRL_MULTI_VECTOR_SELECT_BIT];
        end
    end

    // Arbitration: highest level wins, then highest subpriority,
    // then the lowest source number
    always_comb begin
        next_coreReq = '0;
        for (int s = 0; s < SRC_COUNT; s++) begin
            if (flags[s] && enables[s] && prio[s] != 3'h0) begin
                if (!next_coreReq.valid
                    || prio[s] > next_coreReq.level
                    || (prio[s] == next_coreReq.level
                        && sub[s] > next_coreReq.sub)) begin
                    next_coreReq.valid  = 1'b1;
                    next_coreReq.level  = prio[s];
                    next_coreReq.sub    = sub[s];
                    next_coreReq.vector = 5'(s);
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            coreReq <= '0;
        end else begin
            coreReq <= next_coreReq;
        end
    end

    // A request counts as newly presented when the winner changes
    assign newPresent = next_coreReq.valid
        && (!coreReq.valid
            || next_coreReq.vector != coreReq.vector
            || next_coreReq.level != coreReq.level);

    // Latest presented level and vector, tracked in single-vector mode
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            latestLevel  <= 3'h0;
            latestVector <= 5'h00;
        end else if (newPresent && !multiVector) begin
            latestLevel  <= next_coreReq.level;
            latestVector <= next_coreReq.vector;
        end
    end

    // Block events
    always_comb begin
        events = '0;
        events[`IFP_EV_RAISED]    = |sourceEvent;
        events[`IFP_EV_PRESENTED] = newPresent;
        events[`IFP_EV_OVERRUN]   = |(sourceEvent & flags);
    end

    // Sticky event bits: write one to clear, a new event wins
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irqStatus <= '0;
        end else if (ifp_hit(busReq, `IFP_OFF_IRQ_STATUS)) begin
            irqStatus <= (irqStatus & ~busReq.wrData[`IFP_EV_COUNT-1:0])
                         | events;
        end else begin
            irqStatus <= irqStatus | events;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irqMask <= '0;
        end else if (ifp_hit(busReq, `IFP_OFF_IRQ_MASK)) begin
            irqMask <= busReq.wrData[`IFP_EV_COUNT-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStatus & irqMask);
        end
    end

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        int idx;
        idx = ifp_prio_index(busReq.addr);
        next_rdData = '0;
        if (idx >= 0) begin
            for (int k = 0; k < 4; k++) begin
                next_rdData[k*`IFP_SLOT_STRIDE+`IFP_PRI_LSB +: 3] =
                    prio[idx*4+k];
                next_rdData[k*`IFP_SLOT_STRIDE+`IFP_SUB_LSB +: 2] =
                    sub[idx*4+k];
            end
        end else begin
            case (busReq.addr)
                `IFP_OFF_FLAG: begin
                    next_rdData[SRC_COUNT-1:0] = flags;
                end
                `IFP_OFF_ENABLE: begin
                    next_rdData[SRC_COUNT-1:0] = enables;
                end
                `IFP_OFF_STATUS: begin
                    next_rdData[`IFP_STAT_LEVEL_LSB +: 3] = latestLevel;
                    next_rdData[`IFP_STAT_VEC_LSB +: 5]   = latestVector;
                end
                `IFP_OFF_CONTROL: begin
                    next_rdData[`IFP_CTRL_MULTI_VECTOR_SELECT_BIT] = multiVector;
                end
                `IFP_OFF_IRQ_STATUS: begin
                    next_rdData[`IFP_EV_COUNT-1:0] = irqStatus;
                end
                `IFP_OFF_IRQ_MASK: begin
                    next_rdData[`IFP_EV_COUNT-1:0] = irqMask;
                end
                default: begin
                    next_rdData = '0;
                end
            endcase
        end
    end

    // Read data stand for one cycle after each cycle of the strobe, zero otherwise
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdData <= '0;
        end else if (busReq.rdEn) begin
            rdData <= next_rdData;
        end else begin
            rdData <= '0;
        end
    end

endmodule : ifp_bank
`default_nettype wire

// ==== core/ifp_consts.svh ====
// Notes on behaviour
// - Each source owns one request flag, 32 to a flag register at bits 31 to 0, read and written by software.
// - A flag reads one after its source has raised a request and zero while none has occurred.
// - Each source owns one enable bit, 32 to an enable register; one enables and zero disables it.
// - A priority register holds four 3-bit priority fields, three of them at bits 28-26, 20-18 and 12-10.
// - The lowest source of a priority register has its priority at bits 4-2 and subpriority at bits 1-0.
// - A priority of zero disables its source so that it never reaches the core.
// - Nonzero priority values are levels 1 to 7, with 7 the highest.
// - A priority register holds four 2-bit subpriority fields, three of them at bits 25-24, 17-16 and 9-8.
// - Subpriority values are levels 0 to 3, with 3 the highest.
// - The three bits above each priority field ignore writes and read as zero.
// - Every flag, enable, priority and subpriority bit is zero after reset.
// - In single-vector mode the level of the latest request presented to the core is readable in a 3-bit field.
`ifndef IFP_CONSTS_SVH
`define IFP_CONSTS_SVH

`define IFP_OFF_FLAG        8'h00
`define IFP_OFF_ENABLE      8'h04
`define IFP_OFF_PRIO_FIRST  8'h10
`define IFP_OFF_PRIO_LAST   8'h2C
`define IFP_OFF_STATUS      8'h30
`define IFP_OFF_CONTROL     8'h34
`define IFP_OFF_IRQ_STATUS  8'h38
`define IFP_OFF_IRQ_MASK    8'h3C

`define IFP_SLOT_STRIDE     8
`define IFP_PRI_LSB         2
`define IFP_SUB_LSB         0
`define IFP_STAT_LEVEL_LSB  8
`define IFP_STAT_VEC_LSB    0
`define IFP_CTRL_MULTI_VECTOR_SELECT_BIT   0

`define IFP_EV_RAISED       0
`define IFP_EV_PRESENTED    1
`define IFP_EV_OVERRUN      2
`define IFP_EV_COUNT        3

`define IFP_RST_WORD        32'h0000_0000
`define IFP_RST_PRI         3'h0
`define IFP_RST_SUB         2'h0

`endif

// ==== core/ifp_pkg.sv ====
`default_nettype none
package ifp_pkg;
    typedef logic [2:0] ifp_level_t;
    typedef logic [1:0] ifp_sub_t;

    typedef struct packed {
        logic        wrEn;
        logic        rdEn;
        logic [7:0]  addr;
        logic [31:0] wrData;
    } ifp_bus_s;

    typedef struct packed {
        logic       valid;
        ifp_level_t level;
        ifp_sub_t   sub;
        logic [4:0] vector;
    } ifp_request_s;
endpackage : ifp_pkg
`default_nettype wire

// ==== verif/ifp_bank_properties.sv ====
`default_nettype none
module ifp_bank_properties #(
    parameter int SRC_COUNT = 32
) (
    input wire logic                  core_clk,    // Clock
    input wire logic                  reset_n,     // Reset
    input wire ifp_pkg::ifp_bus_s     busReq,      // Bus
    input wire logic [31:0]           rdData,      // Read data
    input wire logic [SRC_COUNT-1:0]  sourceEvent, // Events
    input wire ifp_pkg::ifp_request_s coreReq,     // Core request
    input wire logic                  irq          // Interrupt
);
    import ifp_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence flagRead;
        busReq.rdEn && busReq.addr == 8'h00;
    endsequence
    chk_rd_idle: assert property (!$past(busReq.rdEn) |-> rdData == 32'h0)
        else $error("read data not idle");
    chk_prio_unused: assert property ($past(busReq.rdEn) &&
        $past(busReq.addr) inside {[8'h10:8'h2C]} |->
        (rdData & 32'hE0E0_E0E0) == 32'h0) else $error("spare bits set");
    chk_flag_seen: assert property (flagRead |=>
        (rdData & 32'($past(sourceEvent, 2))) == 32'($past(sourceEvent, 2)))
        else $error("flag not set");
    chk_flag_kept: assert property (flagRead ##1 flagRead |=>
        (rdData & $past(rdData)) == $past(rdData)) else $error("flag lost");
    chk_valid_level: assert property (coreReq.valid |->
        coreReq.level != 3'h0) else $error("level zero shown");
    chk_req_cause: assert property ($rose(coreReq.valid) |->
        $past(busReq.wrEn, 2) || $past(|sourceEvent, 2))
        else $error("request without cause");
    chk_req_hold: assert property (!$past(busReq.wrEn, 2) &&
        !$past(|sourceEvent, 2) |-> $stable(coreReq))
        else $error("request moved");
    chk_irq_cause: assert property ($rose(irq) |-> $past(busReq.wrEn, 2)
        || $past(busReq.wrEn, 3) || $past(|sourceEvent, 2)
        || $past(|sourceEvent, 3)) else $error("irq without cause");
endmodule : ifp_bank_properties
`default_nettype wire

// ==== verif/ifp_core_model.sv ====
`default_nettype none
module ifp_core_model (
    input  wire logic                  core_clk, // Clock
    input  wire logic                  reset_n,  // Reset
    input  wire ifp_pkg::ifp_request_s coreReq,  // Request in
    output ifp_pkg::ifp_request_s      takenReq  // Last taken
);
    timeunit 1ns;
    timeprecision 1ns;
    import ifp_pkg::*;
    // The core takes whatever valid request the bank presents
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) takenReq <= '0;
        else if (coreReq.valid) takenReq <= coreReq;
    end
endmodule : ifp_core_model
`default_nettype wire

// ==== verif/interrupt_flag_enable_priority_tb.sv ====
`default_nettype none
module interrupt_flag_enable_priority_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ifp_pkg::*;
    logic         core_clk = 1'b0;
    logic         reset_n = 1'b0;
    ifp_bus_s     busReq = '0;
    logic [31:0]  rdData;
    logic [31:0]  sourceEvent = '0;
    ifp_request_s coreReq;
    ifp_request_s takenReq;
    logic         irq;
    int           miscompares = 0;
    int           check_count = 0;
    always #50 core_clk = ~core_clk;
    ifp_bank #(.SRC_COUNT(32)) dut_u (.core_clk(core_clk),
        .reset_n(reset_n), .busReq(busReq), .rdData(rdData),
        .sourceEvent(sourceEvent), .coreReq(coreReq), .irq(irq));
    ifp_core_model core_u (.core_clk(core_clk), .reset_n(reset_n),
        .coreReq(coreReq), .takenReq(takenReq));
    task automatic check(string nm, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge core_clk);
        busReq <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
        @(posedge core_clk);
        busReq <= '0;
    endtask : wr
    task automatic rd(logic [7:0] a, logic [31:0] exp);
        @(posedge core_clk);
        busReq <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 32'h0};
        @(posedge core_clk);
        busReq <= '0;
        @(negedge core_clk);
        check($sformatf("reg %h", a), exp, rdData);
    endtask : rd
    task automatic rd_pair(logic [7:0] a, logic [31:0] exp);
        @(posedge core_clk);
        busReq <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 32'h0};
        @(posedge core_clk);
        @(negedge core_clk);
        check($sformatf("reg %h first", a), exp, rdData);
        @(posedge core_clk);
        busReq <= '0;
        @(negedge core_clk);
        check($sformatf("reg %h second", a), exp, rdData);
    endtask : rd_pair
    task automatic pulse(logic [31:0] m);
        @(posedge core_clk);
        sourceEvent <= m;
        @(posedge core_clk);
        sourceEvent <= '0;
        repeat (3) @(negedge core_clk);
    endtask : pulse
    task automatic req(logic [10:0] exp);
        repeat (2) @(negedge core_clk);
        check("coreReq", {21'h0, exp}, {21'h0, coreReq});
    endtask : req
    task automatic irq_is(logic exp);
        repeat (2) @(negedge core_clk);
        check("irq", {31'h0, exp}, {31'h0, irq});
    endtask : irq_is
    task automatic end_sim;
        if (miscompares == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (3000) @(posedge core_clk);
        miscompares++;
        end_sim;
    end
    initial begin
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        for (int a = 0; a < 'h44; a += 4) rd(8'(a), 32'h0);
        wr(8'h00, 32'hFFFF_FFFF);
        rd(8'h00, 32'hFFFF_FFFF);
        wr(8'h00, 32'h0);
        rd(8'h00, 32'h0);
        wr(8'h04, 32'hA5A5_5A5A);
        rd(8'h04, 32'hA5A5_5A5A);
        for (int a = 'h10; a < 'h30; a += 4) begin
            wr(8'(a), 32'hFFFF_FFFF);
            rd(8'(a), 32'h1F1F_1F1F);
            wr(8'(a), 32'h0);
        end
        wr(8'h11, 32'hFFFF_FFFF);
        rd(8'h10, 32'h0);
        // Sources 0..3: level 3 sub 1, level 3 sub 2, off, level 7 sub 0
        wr(8'h10, 32'h1C03_0E0D);
        rd(8'h10, 32'h1C03_0E0D);
        wr(8'h04, 32'hFFFF_FFFF);
        pulse(32'h4);
        req(11'h000);
        rd(8'h00, 32'h4);
        pulse(32'h3);
        req({1'b1, 3'h3, 2'h2, 5'h01});
        pulse(32'h8);
        req({1'b1, 3'h7, 2'h0, 5'h03});
        rd(8'h30, 32'h0000_0703);
        check("taken", 32'h0000_0783, {21'h0, takenReq});
        wr(8'h00, 32'h7);
        req({1'b1, 3'h3, 2'h2, 5'h01});
        wr(8'h00, 32'h5);
        req({1'b1, 3'h3, 2'h1, 5'h00});
        wr(8'h04, 32'h0);
        req(11'h000);
        rd(8'h38, 32'h3);
        irq_is(1'b0);
        wr(8'h3C, 32'h7);
        irq_is(1'b1);
        wr(8'h38, 32'h3);
        irq_is(1'b0);
        rd(8'h38, 32'h0);
        pulse(32'h4);
        rd(8'h38, 32'h5);
        irq_is(1'b1);
        wr(8'h3C, 32'h0);
        irq_is(1'b0);
        // Back-to-back flag reads keep every set flag
        rd_pair(8'h00, 32'h5);
        // Multi-vector mode leaves the latest-level field untouched
        wr(8'h34, 32'h1);
        rd(8'h34, 32'h1);
        wr(8'h04, 32'h1);
        req({1'b1, 3'h3, 2'h1, 5'h00});
        rd(8'h30, 32'h0000_0300);
        end_sim;
    end
endmodule : interrupt_flag_enable_priority_tb
bind ifp_bank ifp_bank_properties #(.SRC_COUNT(SRC_COUNT)) chk_u (
    .core_clk(core_clk), .reset_n(reset_n), .busReq(busReq),
    .rdData(rdData), .sourceEvent(sourceEvent), .coreReq(coreReq),
    .irq(irq));
`default_nettype wire
